// file: sepw_consts.vh
// Constants for the serial memory write target: select code, register fields, timing.
// Assumes the includer runs on a 40 MHz clock and samples the two bus wires itself.
// Functional notes
// [RULE1] Start is data falling while clock high; watched except while programming. The code watches it while programming too.
// [RULE2] Stop is data rising while clock high; it ends the current transfer.
// [RULE3] Read ended by master no-acknowledge then stop returns device to standby.
// [RULE4] Received bits are captured on each rising serial clock edge.
// [RULE5] Master keeps data stable over rising clock edges, changing it only when low.
// [RULE6] Transmitter releases data after eight bits; receiver pulls low in ninth pulse.
// [RULE7] Master sends select code msb first: type, chip address, direction.
// [RULE8] Only select codes with type field 1010 are accepted.
// [RULE9] Select acknowledged only when its bits 3..1 equal the stored chip address.
// [RULE10] Unacknowledged select: release bus, go standby, ignore rest of transfer.
// [RULE11] Eighth select bit is direction: 1 read, 0 write.
// [RULE12] Write receives two acknowledged address bytes, high first, then data bytes.
// [RULE13] Programming starts only on stop in tenth slot right after data acknowledge.
// [RULE14] After array programming the address counter points past the last byte.
// [RULE15] While programming, data output stays off and no request is answered.
// [RULE16] Write lock set: select and address acknowledged, data refused, array unchanged.
// [RULE17] Page write holds up to 32 bytes; overflow wraps to page offset 0.
// [RULE18] In-page address counter advances after each received data byte.
// [RULE19] Polling select is refused while programming and acknowledged once done.
// [RULE20] Read after polling repeats the upper seven select bits of the poll.
// [RULE21] Chip-enable register writes proceed and are acknowledged regardless of lock.
// [RULE22] Address bit 15 set sends the write to the chip-enable register.
// [RULE23] After reprogramming only the new chip address is acknowledged.
// [RULE24] More than one data byte to the chip-enable register cancels its programming.
// [RULE25] Chip-enable register: bits 3..1 chip address, bit 0 write lock, 7..4 ignored.
// [RULE26] Programming time is a parameterised count of clock cycles.
`ifndef SEPW_CONSTS_VH
`define SEPW_CONSTS_VH

`define SEPW_CLK_PERIOD_NS 25
`define SEPW_PROG_TIME_NS 5000000
`define SEPW_PROG_CYCLES (`SEPW_PROG_TIME_NS / `SEPW_CLK_PERIOD_NS)

`define SEPW_TYPE_ID 4'hA
`define SEPW_CE_RESET 4'h0
`define SEPW_CE_ADDR_MSB 3
`define SEPW_CE_ADDR_LSB 1
`define SEPW_CE_LOCK_BIT 0
`define SEPW_CE_SEL_BIT 15
`define SEPW_PAGE_BYTES 32
`define SEPW_PAGE_W 5
`define SEPW_MEM_ADDR_W 14

`endif

// file: sepw_bus_sense.v
// Bus front end: synchronises the serial clock and data wires and finds edges,
// start and stop. Assumes both wires are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module sepw_bus_sense (
  input wire clk,
  input wire rst,
  input wire sclPin,
  input wire sdaPin,
  output wire sclRise,
  output wire sclFall,
  output wire startDet,
  output wire stopDet,
  output wire sdaBit
);
  reg sclMeta_q;
  reg sclSync_q;
  reg sclPrev_q;
  reg sdaMeta_q;
  reg sdaSync_q;
  reg sdaPrev_q;

  // Idle bus is pulled high, so reset to high
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end
    else
    begin
      sclMeta_q <= sclPin;
      sclSync_q <= sclMeta_q;
      sclPrev_q <= sclSync_q;
      sdaMeta_q <= sdaPin;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
    end
  end

  assign sclRise = sclSync_q & ~sclPrev_q;
  assign sclFall = ~sclSync_q & sclPrev_q;
  // Clock must be high in both samples so a clock edge is never read as a condition
  assign startDet = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q; // see [RULE1]
  assign stopDet = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q; // see [RULE2]
  assign sdaBit = sdaSync_q;
endmodule
`default_nettype wire

// file: sepw_write_slave.v
// Serial memory write target: select decode, acknowledge, address and page
// latching, chip-enable register and timed program cycle with its own array.
// Assumes an external master drives the clock wire and the bench resolves the
// open-drain data wire from sdaOe.
`timescale 1ns/1ps
`default_nettype none
`include "sepw_consts.vh"
module sepw_write_slave #(
  parameter PROG_CYCLES = `SEPW_PROG_CYCLES,
  parameter MEM_ADDR_W = `SEPW_MEM_ADDR_W,
  parameter PAGE_W = `SEPW_PAGE_W
) (
  input wire clk,
  input wire rst,
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  output wire progBusy,
  output wire [2:0] configurableSelectAddress,
  output wire arrayWriteLock,
  input wire [MEM_ADDR_W-1:0] memRdAddr,
  output reg [7:0] memRdData_q
);
  localparam ST_IDLE = 3'd0;
  localparam ST_SEL = 3'd1;
  localparam ST_ADDRH = 3'd2;
  localparam ST_ADDRL = 3'd3;
  localparam ST_DATA = 3'd4;
  localparam ST_IGNORE = 3'd5;
  localparam PAGE_N = 1 << PAGE_W;
  localparam MEM_DEPTH = 1 << MEM_ADDR_W;

  wire sclRise;
  wire sclFall;
  wire startDet;
  wire stopDet;
  wire sdaBit;

  reg [2:0] state_q;
  reg [3:0] bitCnt_q;
  reg [7:0] shift_q;
  reg ackPend_q;
  reg ackWant_q;
  reg ackPhase_q;
  reg ackRose_q;
  reg sdaOe_q;
  reg [2:0] nextState_q;
  reg dataAckDone_q;
  reg [15:0] addr_q;
  reg ceTarget_q;
  reg [1:0] ceCount_q;
  reg [3:0] ceNew_q;
  reg [3:0] ceReg_q;
  reg [PAGE_W-1:0] pagePtr_q;
  reg [PAGE_N-1:0] latchValid_q;
  reg [MEM_ADDR_W-1:0] addrCnt_q;
  reg busy_q;
  reg busyCe_q;
  reg [31:0] progCnt_q;
  reg [7:0] pageLatch [0:PAGE_N-1];
  reg [7:0] memArray [0:MEM_DEPTH-1];

  wire [7:0] byteIn;
  wire byteDone;
  wire selMatch;
  wire slot10Stop;
  wire progDone;
  wire commitNow;
  wire [PAGE_W-1:0] commitIdx;
  wire [MEM_ADDR_W-1:0] pageBase;
  wire [MEM_ADDR_W-1:0] lastWritten;

  sepw_bus_sense uSense (
    .clk(clk),
    .rst(rst),
    .sclPin(sclIn),
    .sdaPin(sdaIn),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startDet(startDet),
    .stopDet(stopDet),
    .sdaBit(sdaBit)
  );

  assign byteIn = {shift_q[6:0], sdaBit};
  // Eighth rising edge of a byte, outside the acknowledge slot
  assign byteDone = sclRise & ~ackPhase_q & (bitCnt_q == 4'd7) & (state_q != ST_IDLE) & (state_q != ST_IGNORE);
  // Type field and chip address must both match, and no program cycle may run
  assign selMatch = (byteIn[7:4] == `SEPW_TYPE_ID) // see [RULE8]
    & (byteIn[`SEPW_CE_ADDR_MSB:`SEPW_CE_ADDR_LSB] == ceReg_q[`SEPW_CE_ADDR_MSB:`SEPW_CE_ADDR_LSB]) // see [RULE9]
    & ~busy_q; // see [RULE19]
  // Stop after one clock of the slot that follows an acknowledged data byte
  assign slot10Stop = stopDet & (state_q == ST_DATA) & dataAckDone_q & ~ackPhase_q & (bitCnt_q == 4'd1); // see [RULE13]
  assign progDone = busy_q & (progCnt_q == PROG_CYCLES - 1);
  assign commitIdx = progCnt_q[PAGE_W-1:0];
  assign commitNow = busy_q & ~busyCe_q & (progCnt_q < PAGE_N) & latchValid_q[commitIdx];
  assign pageBase = {addr_q[MEM_ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};
  assign lastWritten = {addr_q[MEM_ADDR_W-1:PAGE_W], pagePtr_q - {{(PAGE_W-1){1'b0}}, 1'b1}};

  // Open drain: the wire is only ever pulled low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_q & ~busy_q; // see [RULE15]
  assign progBusy = busy_q;
  assign configurableSelectAddress = ceReg_q[`SEPW_CE_ADDR_MSB:`SEPW_CE_ADDR_LSB];
  assign arrayWriteLock = ceReg_q[`SEPW_CE_LOCK_BIT];

  // Protocol engine
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      ackPend_q <= 1'b0;
      ackWant_q <= 1'b0;
      ackPhase_q <= 1'b0;
      ackRose_q <= 1'b0;
      sdaOe_q <= 1'b0;
      nextState_q <= ST_IDLE;
      dataAckDone_q <= 1'b0;
      addr_q <= 16'h0000;
      ceTarget_q <= 1'b0;
      ceCount_q <= 2'd0;
      ceNew_q <= 4'h0;
      pagePtr_q <= {PAGE_W{1'b0}};
      latchValid_q <= {PAGE_N{1'b0}};
    end
    else if (stopDet)
    begin
      // A stop always ends the transfer and frees the wire
      state_q <= ST_IDLE; // see [RULE2] see [RULE3]
      sdaOe_q <= 1'b0;
      ackPend_q <= 1'b0;
      ackPhase_q <= 1'b0;
      ackRose_q <= 1'b0;
      bitCnt_q <= 4'h0;
      dataAckDone_q <= 1'b0;
    end
    else if (startDet)
    begin
      // Also a repeated start; a poll during programming is refused at select time
      state_q <= ST_SEL; // see [RULE1]
      sdaOe_q <= 1'b0;
      ackPend_q <= 1'b0;
      ackPhase_q <= 1'b0;
      ackRose_q <= 1'b0;
      bitCnt_q <= 4'h0;
      dataAckDone_q <= 1'b0;
      if (!busy_q)
      begin
        latchValid_q <= {PAGE_N{1'b0}};
      end
    end
    else
    begin
      if (sclRise && !ackPhase_q && state_q != ST_IDLE && state_q != ST_IGNORE)
      begin
        shift_q <= byteIn; // see [RULE4]
        bitCnt_q <= (bitCnt_q == 4'd7) ? 4'h0 : bitCnt_q + 4'd1;
        if (bitCnt_q == 4'd7)
        begin
          dataAckDone_q <= 1'b0;
        end
      end
      if (sclRise && ackPhase_q)
      begin
        ackRose_q <= 1'b1;
      end
      if (byteDone)
      begin
        ackPend_q <= 1'b1;
        case (state_q)
          ST_SEL:
          begin
            ackWant_q <= selMatch;
            // Reads are not served here: after the acknowledge the wire is left alone
            nextState_q <= !selMatch ? ST_IGNORE : (byteIn[0] ? ST_IGNORE : ST_ADDRH); // see [RULE10] see [RULE11]
          end
          ST_ADDRH:
          begin
            ackWant_q <= 1'b1; // see [RULE12] see [RULE16]
            addr_q[15:8] <= byteIn;
            nextState_q <= ST_ADDRL;
          end
          ST_ADDRL:
          begin
            ackWant_q <= 1'b1; // see [RULE12]
            addr_q[7:0] <= byteIn;
            ceTarget_q <= addr_q[`SEPW_CE_SEL_BIT]; // see [RULE22]
            ceCount_q <= 2'd0;
            pagePtr_q <= byteIn[PAGE_W-1:0];
            latchValid_q <= {PAGE_N{1'b0}};
            nextState_q <= ST_DATA;
          end
          ST_DATA:
          begin
            nextState_q <= ST_DATA;
            if (ceTarget_q)
            begin
              ackWant_q <= 1'b1; // see [RULE21]
              ceNew_q <= byteIn[3:0]; // see [RULE25]
              ceCount_q <= (ceCount_q == 2'd2) ? 2'd2 : ceCount_q + 2'd1;
            end
            else if (ceReg_q[`SEPW_CE_LOCK_BIT])
            begin
              ackWant_q <= 1'b0; // see [RULE16]
            end
            else
            begin
              ackWant_q <= 1'b1;
              latchValid_q[pagePtr_q] <= 1'b1;
              // Pointer is PAGE_W bits wide so it wraps inside the page
              pagePtr_q <= pagePtr_q + {{(PAGE_W-1){1'b0}}, 1'b1}; // see [RULE17] see [RULE18]
            end
          end
          default:
          begin
            ackWant_q <= 1'b0;
            nextState_q <= ST_IGNORE;
          end
        endcase
      end
      if (sclFall && ackPend_q)
      begin
        ackPend_q <= 1'b0;
        ackPhase_q <= 1'b1;
        sdaOe_q <= ackWant_q; // see [RULE6]
      end
      else if (sclFall && ackPhase_q && ackRose_q)
      begin
        ackPhase_q <= 1'b0;
        ackRose_q <= 1'b0;
        sdaOe_q <= 1'b0;
        state_q <= ackWant_q ? nextState_q : ((state_q == ST_DATA) ? ST_DATA : ST_IGNORE); // see [RULE10]
        dataAckDone_q <= ackWant_q & (state_q == ST_DATA);
      end
    end
  end

  // Page latch holds the data until the program cycle copies it
  always @(posedge clk)
  begin
    if (byteDone && state_q == ST_DATA && !ceTarget_q && !ceReg_q[`SEPW_CE_LOCK_BIT])
    begin
      pageLatch[pagePtr_q] <= byteIn;
    end
  end

  // Program cycle, chip-enable register and address counter
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      busyCe_q <= 1'b0;
      progCnt_q <= 32'h0000_0000;
      ceReg_q <= `SEPW_CE_RESET;
      addrCnt_q <= {MEM_ADDR_W{1'b0}};
    end
    else if (busy_q)
    begin
      progCnt_q <= progCnt_q + 32'h0000_0001; // see [RULE26]
      if (progDone)
      begin
        busy_q <= 1'b0;
        if (busyCe_q)
        begin
          ceReg_q <= ceNew_q; // see [RULE23]
        end
        else
        begin
          addrCnt_q <= lastWritten + {{(MEM_ADDR_W-1){1'b0}}, 1'b1}; // see [RULE14]
        end
      end
    end
    else if (slot10Stop)
    begin
      // Register write with extra bytes is dropped without a program cycle
      if (ceTarget_q && ceCount_q == 2'd1)
      begin
        busy_q <= 1'b1; // see [RULE24]
        busyCe_q <= 1'b1;
        progCnt_q <= 32'h0000_0000;
      end
      else if (!ceTarget_q && latchValid_q != {PAGE_N{1'b0}})
      begin
        busy_q <= 1'b1;
        busyCe_q <= 1'b0;
        progCnt_q <= 32'h0000_0000;
      end
    end
  end

  // Copy one latched byte per cycle early in the program cycle; PROG_CYCLES must be at least the page size
  always @(posedge clk)
  begin
    if (commitNow)
    begin
      memArray[pageBase | {{(MEM_ADDR_W-PAGE_W){1'b0}}, commitIdx}] <= pageLatch[commitIdx]; // see [RULE17]
    end
  end

  // Inspection port; array has no reset so its contents start unknown
  always @(posedge clk)
  begin
    memRdData_q <= memArray[memRdAddr];
  end
endmodule
`default_nettype wire

// file: sepw_write_slave_properties.sv
// Port checker for the serial memory write target.
// Assumes clk is the only clock and rst clears every register but the array, page latch and read data.
`timescale 1ns/1ps
`default_nettype none
module sepw_write_slave_checker #(
  parameter PROG_CYCLES = 64,
  parameter MEM_ADDR_W = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic progBusy,
  input wire logic [2:0] configurableSelectAddress,
  input wire logic arrayWriteLock,
  input wire logic [MEM_ADDR_W-1:0] memRdAddr,
  input wire logic [7:0] memRdData_q
);
  int busyCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Counter, since the busy span is far beyond a repetition
  always @(posedge clk or posedge rst)
    if (rst)
      busyCnt <= 0;
    else if (progBusy)
      busyCnt <= busyCnt + 1;
    else
      busyCnt <= 0;
  a_busy_no_ack: assert property (progBusy |-> !sdaOe)
    else $error("acknowledge driven while programming");
  a_busy_length: assert property ($fell(progBusy) |-> busyCnt >= PROG_CYCLES - 1 && busyCnt <= PROG_CYCLES + 1)
    else $error("program cycle length wrong");
  a_busy_after_stop: assert property ($rose(progBusy) |-> $past(sdaIn) && $past(sclIn))
    else $error("program cycle without stop");
  a_ack_after_fall: assert property ($rose(sdaOe) |-> !$past(sclIn, 2))
    else $error("acknowledge not started in clock low");
  a_ack_holds: assert property ($rose(sdaOe) |=> sdaOe [*4])
    else $error("acknowledge too short");
  a_ack_released: assert property ($rose(sdaOe) |-> ##[4:16] !sdaOe)
    else $error("acknowledge never released");
  a_drive_zero: assert property (sdaOe |-> !sdaOut)
    else $error("data wire driven high");
  a_cfg_stable: assert property (!progBusy && !$past(progBusy) && !$past(progBusy, 2)
    |-> $stable(configurableSelectAddress) && $stable(arrayWriteLock))
    else $error("register changed outside program cycle");
  c_prog: cover property ($rose(progBusy));
  c_ack: cover property ($rose(sdaOe));
  c_lock: cover property ($rose(arrayWriteLock));
endmodule
bind sepw_write_slave sepw_write_slave_checker #(.PROG_CYCLES(PROG_CYCLES), .MEM_ADDR_W(MEM_ADDR_W)) u_chk (
  .clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .progBusy(progBusy),
  .configurableSelectAddress(configurableSelectAddress), .arrayWriteLock(arrayWriteLock),
  .memRdAddr(memRdAddr), .memRdData_q(memRdData_q));
`default_nettype wire

// file: sepw_i2c_master.sv
// Bus master model: makes the serial clock and pulls the data wire low.
// Assumes a pull-up resolves the wire outside; clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module sepw_i2c_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sdaLow
);
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Also serves as repeated start from clock low
  task automatic start();
    tick(1);
    sdaLow <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic bitIo(input logic b, output logic s);
    tick(1);
    sdaLow <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(2);
    s = sda;
    tick(2);
    scl <= 1'b0;
  endtask
  task automatic byteIo(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitIo(d[i], s);
    bitIo(1'b1, s);
    ack = ~s;
  endtask
  task automatic stop();
    tick(1);
    sdaLow <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b0;
    tick(4);
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Testbench for the serial memory write target with a master model.
// Assumes a pull-up on the data wire; short program time for speed.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PC = 400;
  logic clk, rst, scl, mLow, sda, sdaOut, sdaOe, progBusy, arrayWriteLock;
  logic [2:0] configurableSelectAddress;
  logic [13:0] memRdAddr;
  logic [7:0] memRdData_q;
  logic [3:0] k;
  int fail_count = 0;
  int tests_run = 0;
  assign sda = ~(mLow | (sdaOe & ~sdaOut));
  sepw_write_slave #(.PROG_CYCLES(PC)) u_sepw_write_slave (.clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .progBusy(progBusy), .configurableSelectAddress(configurableSelectAddress),
    .arrayWriteLock(arrayWriteLock), .memRdAddr(memRdAddr), .memRdData_q(memRdData_q));
  sepw_i2c_master u_sepw_i2c_master (.clk(clk), .sda(sda), .scl(scl), .sdaLow(mLow));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      fail_count++;
    end
  endtask
  function automatic logic [7:0] sel(input logic [2:0] c);
    return {4'hA, c, 1'b0};
  endfunction
  task automatic wr(input logic [7:0] s, input logic [15:0] a, input int n, input logic [7:0] d);
    logic x;
    u_sepw_i2c_master.start();
    u_sepw_i2c_master.byteIo(s, k[0]);
    u_sepw_i2c_master.byteIo(a[15:8], k[1]);
    u_sepw_i2c_master.byteIo(a[7:0], k[2]);
    k[3] = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      u_sepw_i2c_master.byteIo(d + 8'(i), x);
      k[3] = k[3] & x;
    end
    u_sepw_i2c_master.stop();
  endtask
  task automatic waitIdle();
    int c = 0;
    while (progBusy !== 1'b0 && c < 1000)
    begin
      @(posedge clk);
      c++;
    end
    chk("progBusy", 0, progBusy);
  endtask
  task automatic peek(input logic [13:0] a, input logic [7:0] e);
    memRdAddr <= a;
    repeat (3) @(posedge clk);
    chk("array byte", e, memRdData_q);
  endtask
  task automatic t_byte_poll();
    logic a;
    wr(sel(3'h0), 16'h0123, 1, 8'h5A);
    chk("acks", 4'hF, k);
    chk("progBusy", 1, progBusy);
    u_sepw_i2c_master.start();
    u_sepw_i2c_master.byteIo(sel(3'h0), a);
    chk("poll busy", 0, a);
    u_sepw_i2c_master.stop();
    waitIdle();
    u_sepw_i2c_master.start();
    u_sepw_i2c_master.byteIo(sel(3'h0), a);
    chk("poll done", 1, a);
    // Repeated start: read select keeps the poll's upper seven bits
    u_sepw_i2c_master.start();
    u_sepw_i2c_master.byteIo(sel(3'h0) | 8'h01, a);
    chk("read select", 1, a);
    u_sepw_i2c_master.stop();
    peek(14'h0123, 8'h5A);
  endtask
  task automatic t_page_wrap();
    wr(sel(3'h0), 16'h005E, 3, 8'h10);
    chk("page acks", 4'hF, k);
    waitIdle();
    peek(14'h005E, 8'h10);
    peek(14'h005F, 8'h11);
    peek(14'h0040, 8'h12);
  endtask
  task automatic t_reject();
    wr(8'hB0, 16'h0123, 1, 8'h77);
    chk("bad type", 0, k[2:0]);
    wr(sel(3'h1), 16'h0123, 1, 8'h77);
    chk("bad chip", 0, k[2:0]);
    chk("progBusy", 0, progBusy);
    wr(sel(3'h0), 16'h0200, 0, 8'h00);
    chk("no data", 4'hF, k);
    chk("progBusy", 0, progBusy);
  endtask
  task automatic t_register();
    wr(sel(3'h0), 16'h8000, 1, 8'h01);
    waitIdle();
    chk("lock", 1, arrayWriteLock);
    wr(sel(3'h0), 16'h0123, 1, 8'hC3);
    chk("locked acks", 4'h7, k);
    chk("progBusy", 0, progBusy);
    peek(14'h0123, 8'h5A);
    wr(sel(3'h0), 16'hF0F0, 1, 8'hFA);
    chk("cfg acks", 4'hF, k);
    waitIdle();
    chk("chip addr", 3'h5, configurableSelectAddress);
    chk("lock", 0, arrayWriteLock);
    wr(sel(3'h0), 16'h0100, 0, 8'h00);
    chk("old chip", 0, k[0]);
    wr(sel(3'h5), 16'h8000, 2, 8'h00);
    chk("two bytes", 4'hF, k);
    chk("progBusy", 0, progBusy);
    chk("chip addr", 3'h5, configurableSelectAddress);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    test_done();
  end
  initial
  begin
    rst = 1'b1;
    memRdAddr = 14'h0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("chip addr", 3'h0, configurableSelectAddress);
    t_byte_poll();
    t_page_wrap();
    t_reject();
    t_register();
    test_done();
  end
endmodule
`default_nettype wire
